// ### design/ext_bus_port.sv
// External memory interface with shared port four and port five pins.
// Assumes clk_i is the oscillator input and all pins are outside its domain.
`timescale 1ns/1ps

// Notes on behaviour
// - Port four carries address then data.
// - Port four I/O direction set as unit.
// - External access low forces port four bus.
// - External access low drives port five address.
// - Memory size picks port five address lines.
// - Unclaimed port five lines stay ordinary I/O.
// - Port five direction chosen per bit.
// - Mapping register sets size and waits.
// - Read strobe low while memory drives data.
// - Write strobe low while device drives data.
// - Refresh pulse at four selectable intervals.
// - Refresh only after bus cycles, never overlapping.
// - Reset forces every register to default.
// - System clock is half the oscillator.
// - Top 256 bytes go to on-chip registers.
// - I/O lines drive latch or float.
// - Address latch strobe during first state.
module ext_bus_port
#(
    parameter int REFRESH_CYC = ext_bus_pkg::REFRESH_BASE_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ext_access_n_i,
    input wire logic cfg_we_i,
    input wire logic [2:0] cfg_sel_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic req_valid_i,
    input wire logic req_we_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic [7:0] sfr_rdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_rdata_o,
    output logic sfr_sel_o,
    output logic sys_clk_o,
    output logic [7:0] port_four_in_o,
    output logic [7:0] port_five_in_o,
    input wire logic [7:0] port_four_i,
    output logic [7:0] port_four_o,
    output logic port_four_oe_o,
    input wire logic [7:0] port_five_i,
    output logic [7:0] port_five_o,
    output logic [7:0] port_five_oe_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic refresh_pulse_n_o
);
    import ext_bus_pkg::*;

    // Refuse a refresh base too short for a bus cycle or too long for the timer.
    // The widest interval shifts the base left by three, and it must fit 12 bits.
    if (REFRESH_CYC < 16 || REFRESH_CYC > 511)
    begin : g_bad_cyc
        $error("REFRESH_CYC out of range");
    end

    typedef struct packed {
        logic phase;
        logic ea_s1;
        logic ea_s2;
        logic [7:0] p4_s1;
        logic [7:0] p4_s2;
        logic [7:0] p5_s1;
        logic [7:0] p5_s2;
        logic [7:0] p4_latch;
        logic [7:0] p5_latch;
        logic [7:0] p4_mode;
        logic [7:0] p5_mode;
        logic [7:0] mem_map;
        logic [7:0] refresh;
        bus_state_e st;
        logic [1:0] wait_cnt;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rsp_valid;
        logic [7:0] rdata;
        logic sfr_sel;
        logic [11:0] ref_cnt;
        logic ref_due;
        logic [7:0] p4_out;
        logic p4_oe;
        logic [7:0] p5_out;
        logic [7:0] p5_oe;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic rf_n;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic tick;
    logic bus_mode;
    logic [7:0] addr_mask;
    logic [11:0] ref_period;

    // Port five lines claimed for high address by the memory size.
    function automatic logic [7:0] high_addr_mask(input logic [2:0] size, input logic ea_n);
        logic [7:0] m;
        m = 8'hFF;
        if (ea_n)
        begin
            unique case (size)
                SIZE_NONE, SIZE_256: m = 8'h00;
                SIZE_4K: m = 8'h0F;
                SIZE_16K: m = 8'h3F;
                default: m = 8'hFF;
            endcase
        end
        return m;
    endfunction : high_addr_mask

    // ****************************************
    // Derived controls
    // ****************************************
    // The system state advances on every second oscillator edge.
    assign tick = s_q.phase;
    assign bus_mode = !s_q.ea_s2 || (s_q.mem_map[MM_SIZE_LSB +: 3] != SIZE_NONE);
    assign addr_mask = high_addr_mask(s_q.mem_map[MM_SIZE_LSB +: 3], s_q.ea_s2);
    assign ref_period = 12'(REFRESH_CYC << s_q.refresh[RF_SEL_LSB +: 2]);
    assign req_ready_o = (s_q.st == ST_IDLE) && tick && !s_q.ref_due;

    // ****************************************
    // Next-state logic
    // ****************************************
    // Builds the whole next state, pins included, so every pin leaves a flop.
    always_comb
    begin
        s_d = s_q;
        s_d.phase = !s_q.phase;
        s_d.ea_s1 = ext_access_n_i;
        s_d.ea_s2 = s_q.ea_s1;
        s_d.p4_s1 = port_four_i;
        s_d.p4_s2 = s_q.p4_s1;
        s_d.p5_s1 = port_five_i;
        s_d.p5_s2 = s_q.p5_s1;
        s_d.rsp_valid = 1'b0;
        s_d.sfr_sel = 1'b0;
        // Software writes to latches and configuration.
        if (cfg_we_i)
        begin
            unique case (cfg_sel_i)
                SEL_PORT_FOUR: s_d.p4_latch = cfg_wdata_i;
                SEL_PORT_FIVE: s_d.p5_latch = cfg_wdata_i;
                SEL_MODE_FOUR: s_d.p4_mode = cfg_wdata_i;
                SEL_MODE_FIVE: s_d.p5_mode = cfg_wdata_i;
                SEL_MEM_MAP: s_d.mem_map = cfg_wdata_i;
                SEL_REFRESH: s_d.refresh = cfg_wdata_i;
                default: s_d.mem_map = s_q.mem_map;
            endcase
        end
        // Refresh interval timer; an expiry wins over the clear below.
        if (!s_q.refresh[RF_EN_BIT])
        begin
            s_d.ref_cnt = '0;
        end
        else if (s_q.ref_cnt >= ref_period - 12'h001)
        begin
            s_d.ref_cnt = '0;
        end
        else
        begin
            s_d.ref_cnt = s_q.ref_cnt + 12'h001;
        end
        // Bus sequencer, one step per system state.
        if (tick)
        begin
            unique case (s_q.st)
                ST_IDLE:
                begin
                    if (s_q.ref_due)
                    begin
                        s_d.st = ST_REFRESH;
                        s_d.ref_due = 1'b0;
                    end
                    else if (req_valid_i && req_addr_i[15:8] == SFR_PAGE)
                    begin
                        s_d.sfr_sel = 1'b1;
                        s_d.rsp_valid = 1'b1;
                        s_d.rdata = sfr_rdata_i;
                    end
                    else if (req_valid_i && !bus_mode)
                    begin
                        s_d.rsp_valid = 1'b1;
                        s_d.rdata = NO_MEM_DATA;
                    end
                    else if (req_valid_i)
                    begin
                        s_d.st = ST_ADDR;
                        s_d.we = req_we_i;
                        s_d.addr = req_addr_i;
                        s_d.wdata = req_wdata_i;
                    end
                end
                ST_ADDR:
                begin
                    s_d.st = ST_STROBE;
                    s_d.wait_cnt = s_q.mem_map[MM_WAIT_LSB +: 2];
                end
                ST_STROBE:
                begin
                    if (s_q.wait_cnt != 2'h0)
                    begin
                        s_d.wait_cnt = s_q.wait_cnt - 2'h1;
                    end
                    else
                    begin
                        s_d.st = ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    s_d.st = ST_IDLE;
                    s_d.rsp_valid = 1'b1;
                    s_d.rdata = s_q.we ? s_q.wdata : s_q.p4_s2;
                end
                ST_REFRESH: s_d.st = ST_IDLE;
            endcase
        end
        if (s_q.refresh[RF_EN_BIT] && s_q.ref_cnt >= ref_period - 12'h001)
        begin
            s_d.ref_due = 1'b1;
        end
        // Pin drives for the state about to be entered.
        s_d.ale = (s_d.st == ST_ADDR);
        s_d.rd_n = !((s_d.st == ST_STROBE || s_d.st == ST_HOLD) && !s_d.we);
        s_d.wr_n = !((s_d.st == ST_STROBE || s_d.st == ST_HOLD) && s_d.we);
        s_d.rf_n = (s_d.st != ST_REFRESH);
        if (s_d.st == ST_ADDR)
        begin
            s_d.p4_out = s_d.addr[7:0];
            s_d.p4_oe = 1'b1;
        end
        else if (s_d.st == ST_STROBE || s_d.st == ST_HOLD)
        begin
            s_d.p4_out = s_d.wdata;
            s_d.p4_oe = s_d.we;
        end
        else if (bus_mode)
        begin
            s_d.p4_out = s_q.p4_latch;
            s_d.p4_oe = 1'b0;
        end
        else
        begin
            s_d.p4_out = s_q.p4_latch;
            s_d.p4_oe = !s_q.p4_mode[0];
        end
        // Claimed lines carry the high address, the rest act per bit.
        for (int i = 0; i < 8; i++)
        begin
            if (addr_mask[i])
            begin
                s_d.p5_out[i] = s_d.addr[8 + i];
                s_d.p5_oe[i] = 1'b1;
            end
            else
            begin
                s_d.p5_out[i] = s_q.p5_latch[i];
                s_d.p5_oe[i] = !s_q.p5_mode[i];
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset loads every register with its documented default.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
            s_q.ea_s1 <= 1'b1;
            s_q.ea_s2 <= 1'b1;
            s_q.p4_latch <= LATCH_RESET;
            s_q.p5_latch <= LATCH_RESET;
            s_q.p4_mode <= MODE_RESET;
            s_q.p5_mode <= MODE_RESET;
            s_q.mem_map <= MEM_MAP_RESET;
            s_q.refresh <= REFRESH_RESET;
            s_q.st <= ST_IDLE;
            s_q.ale <= 1'b0;
            s_q.rd_n <= 1'b1;
            s_q.wr_n <= 1'b1;
            s_q.rf_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops.
    assign rsp_valid_o = s_q.rsp_valid;
    assign rsp_rdata_o = s_q.rdata;
    assign sfr_sel_o = s_q.sfr_sel;
    assign sys_clk_o = s_q.phase;
    assign port_four_in_o = s_q.p4_s2;
    assign port_five_in_o = s_q.p5_s2;
    assign port_four_o = s_q.p4_out;
    assign port_four_oe_o = s_q.p4_oe;
    assign port_five_o = s_q.p5_out;
    assign port_five_oe_o = s_q.p5_oe;
    assign ale_o = s_q.ale;
    assign rd_n_o = s_q.rd_n;
    assign wr_n_o = s_q.wr_n;
    assign refresh_pulse_n_o = s_q.rf_n;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_addr_state;
        ale_o && port_four_oe_o && port_four_o == s_q.addr[7:0];
    endsequence
    sequence s_strobe_follow;
        !ale_o && (!rd_n_o || !wr_n_o);
    endsequence

    property p_mux;
        $rose(ale_o) |-> s_addr_state ##1 s_addr_state ##2 s_strobe_follow;
    endproperty
    a_mux: assert property (p_mux) else $error("address phase wrong");
    property p_idle;
        (s_q.st == ST_IDLE) |-> rd_n_o && wr_n_o && refresh_pulse_n_o && !ale_o;
    endproperty
    a_idle: assert property (p_idle) else $error("strobe active in idle");
    property p_read;
        !rd_n_o |-> !port_four_oe_o && wr_n_o && !s_q.we;
    endproperty
    a_read: assert property (p_read) else $error("bus driven during read");
    property p_write;
        !wr_n_o |-> port_four_oe_o && port_four_o == s_q.wdata;
    endproperty
    a_write: assert property (p_write) else $error("write data not driven");
    property p_ea_four;
        $past(!s_q.ea_s2) && s_q.st == ST_IDLE |-> !port_four_oe_o;
    endproperty
    a_ea_four: assert property (p_ea_four) else $error("port four not bus");
    property p_ea_five;
        $past(!s_q.ea_s2) |-> port_five_oe_o == 8'hFF;
    endproperty
    a_ea_five: assert property (p_ea_five) else $error("port five not address");
    property p_refresh;
        !refresh_pulse_n_o |-> rd_n_o && wr_n_o && $past(rd_n_o, 2) && $past(wr_n_o, 2);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh overlaps access");
    property p_half;
        $past(rst_b_i) |-> sys_clk_o != $past(sys_clk_o);
    endproperty
    a_half: assert property (p_half) else $error("system clock not halved");
    property p_sfr;
        req_ready_o && req_valid_i && req_addr_i[15:8] == 8'hFF |=> sfr_sel_o && rsp_valid_o
            ##1 ale_o == 1'b0;
    endproperty
    a_sfr: assert property (p_sfr) else $error("register page went external");
    property p_rf_len;
        $fell(refresh_pulse_n_o) |-> ##1 !refresh_pulse_n_o ##1 refresh_pulse_n_o;
    endproperty
    a_rf_len: assert property (p_rf_len) else $error("refresh pulse length wrong");

endmodule : ext_bus_port

// ### include/ext_bus_pkg.sv
// Constants and types shared by the external bus port block.
// Assumes a single 100 MHz oscillator-rate clock feeding the block.
package ext_bus_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int REFRESH_BASE_NS = 2670;
    localparam int REFRESH_BASE_CYC = (REFRESH_BASE_NS * CLK_MHZ) / 1000;

    // ****************************************
    // Configuration register selects
    // ****************************************
    localparam logic [2:0] SEL_PORT_FOUR = 3'h0;
    localparam logic [2:0] SEL_PORT_FIVE = 3'h1;
    localparam logic [2:0] SEL_MODE_FOUR = 3'h2;
    localparam logic [2:0] SEL_MODE_FIVE = 3'h3;
    localparam logic [2:0] SEL_MEM_MAP = 3'h4;
    localparam logic [2:0] SEL_REFRESH = 3'h5;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int MM_SIZE_LSB = 0;
    localparam int MM_WAIT_LSB = 4;
    localparam int RF_SEL_LSB = 0;
    localparam int RF_EN_BIT = 7;
    localparam logic [7:0] MODE_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] MEM_MAP_RESET = 8'h00;
    localparam logic [7:0] REFRESH_RESET = 8'h00;
    localparam logic [7:0] SFR_PAGE = 8'hFF;
    localparam logic [7:0] NO_MEM_DATA = 8'hFF;

    // ****************************************
    // External memory sizes
    // ****************************************
    localparam logic [2:0] SIZE_NONE = 3'h0;
    localparam logic [2:0] SIZE_256 = 3'h1;
    localparam logic [2:0] SIZE_4K = 3'h2;
    localparam logic [2:0] SIZE_16K = 3'h3;

    // Bus sequencer states; ST_ADDR, ST_HOLD and ST_REFRESH last one system state (two clocks), ST_STROBE one plus the wait count.
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_HOLD, ST_REFRESH} bus_state_e;

endpackage : ext_bus_pkg

// ### test/ext_mem_model.sv
// Behavioural external memory hung on the multiplexed bus.
// Assumes the bench resolves the bus wire and feeds it back here.
`timescale 1ns/1ps
module ext_mem_model
(
    input wire logic clk_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] bus_i,
    input wire logic [7:0] high_i,
    output logic [7:0] data_o
);
    // ********
    // Storage and capture
    // ********
    logic [7:0] mem_q [0:65535];
    logic [15:0] addr_q;
    logic [7:0] wdat_q;
    logic [7:0] last_q;
    logic wr_q;
    // Latch the address on the strobe and take write data while strobed.
    always @(posedge clk_i)
    begin
        last_q <= bus_i;
        wr_q <= ~wr_n_i;
        if (ale_i)
            addr_q <= {high_i, bus_i};
        if (!wr_n_i)
            wdat_q <= bus_i;
        if (wr_q && wr_n_i)
            mem_q[addr_q] <= wdat_q;
    end
    // Drive only under the read strobe; a released bus wanders each cycle.
    assign data_o = !rd_n_i ? mem_q[addr_q] : ~last_q;
endmodule : ext_mem_model

// ### test/testbench.sv
// Self-checking bench for the external bus port block.
// Assumes the external memory model stands on the bus pins.
`timescale 1ns/1ps
module testbench;
    import ext_bus_pkg::*;
    // ********
    // Bench state
    // ********
    typedef struct {
        logic ea;
        logic [7:0] map;
        logic we;
        logic [15:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
        logic ext;
    } row_s;
    localparam int REF = 16;
    localparam int LIM = 700;
    row_s rows [13];
    int bad_count = 0;
    int samples_checked = 0;
    int ale_cnt = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    logic [15:0] lat;
    logic [8:0] st;
    logic rf_q;
    logic clk_i = 0;
    logic rst_b_i = 0;
    logic ext_access_n_i = 1;
    logic cfg_we_i = 0;
    logic [2:0] cfg_sel_i = 3'h0;
    logic [7:0] cfg_wdata_i = 8'h00;
    logic req_valid_i = 0;
    logic req_we_i = 0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [7:0] req_wdata_i = 8'h00;
    logic [7:0] p5_ext = 8'h0F;
    logic req_ready_o, rsp_valid_o, sfr_sel_o, sys_clk_o, port_four_oe_o;
    logic ale_o, rd_n_o, wr_n_o, refresh_pulse_n_o;
    logic [7:0] rsp_rdata_o, p4_in, p5_in, port_four_o, port_five_o, p5_oe, mem_data;
    wire [7:0] port_four_i = port_four_oe_o ? port_four_o : mem_data;
    wire [7:0] port_five_i = (p5_oe & port_five_o) | (~p5_oe & p5_ext);
    wire [12:0] idle_pins = {rd_n_o, wr_n_o, refresh_pulse_n_o, ale_o, port_four_oe_o, p5_oe};

    ext_bus_port #(.REFRESH_CYC(REF)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .ext_access_n_i(ext_access_n_i), .cfg_we_i(cfg_we_i), .cfg_sel_i(cfg_sel_i),
        .cfg_wdata_i(cfg_wdata_i), .req_valid_i(req_valid_i), .req_we_i(req_we_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .sfr_rdata_i(8'h5E),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .sfr_sel_o(sfr_sel_o), .sys_clk_o(sys_clk_o), .port_four_in_o(p4_in),
        .port_five_in_o(p5_in), .port_four_i(port_four_i), .port_four_o(port_four_o),
        .port_four_oe_o(port_four_oe_o), .port_five_i(port_five_i),
        .port_five_o(port_five_o), .port_five_oe_o(p5_oe), .ale_o(ale_o), .rd_n_o(rd_n_o),
        .wr_n_o(wr_n_o), .refresh_pulse_n_o(refresh_pulse_n_o));
    ext_mem_model mem_u (.clk_i(clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
        .bus_i(port_four_i), .high_i(port_five_o), .data_o(mem_data));

    // The clock toggles every half period of 5 ns.
    always #5 clk_i = ~clk_i;

    // Watch the cycle in flight and flag any refresh pulse during it.
    always @(posedge clk_i)
    begin
        rf_q <= refresh_pulse_n_o;
        ale_cnt += ale_o;
        rd_cnt += !rd_n_o;
        wr_cnt += !wr_n_o;
        if (ale_o)
            lat = {port_five_o, port_four_o};
        if (!rd_n_o || !wr_n_o)
            st = {port_four_oe_o, port_four_o};
        if (rst_b_i)
            check(16'(!refresh_pulse_n_o && (ale_o || !rd_n_o || !wr_n_o)), 16'h0000, "ovl");
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic guard(input int n);
        if (n >= LIM)
        begin
            check(16'(n), 16'h0000, "wait bound");
            summarize();
        end
    endtask : guard

    function automatic logic [7:0] hi_mask(input logic ea, input logic [2:0] sz);
        if (!ea || sz > SIZE_16K)
            return 8'hFF;
        if (sz == SIZE_16K)
            return 8'h3F;
        return sz == SIZE_4K ? 8'h0F : 8'h00;
    endfunction : hi_mask

    task automatic cfg(input logic [2:0] sel, input logic [7:0] d);
        @(posedge clk_i);
        cfg_we_i <= 1'b1;
        cfg_sel_i <= sel;
        cfg_wdata_i <= d;
        @(posedge clk_i);
        cfg_we_i <= 1'b0;
    endtask : cfg

    // Counts falling clock edges until the refresh output has just fallen.
    task automatic wait_fall(output int n);
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end while (!(refresh_pulse_n_o === 1'b0 && rf_q === 1'b1) && n < LIM);
    endtask : wait_fall

    // One request: held until taken, then timed and checked at the response.
    task automatic run_row(input row_s r);
        int n;
        int w;
        logic [15:0] m;
        @(posedge clk_i);
        ext_access_n_i <= r.ea;
        cfg(SEL_MEM_MAP, r.map);
        repeat (4) @(posedge clk_i);
        w = r.ext ? 2 * (3 + int'(r.map[5:4])) : 0;
        m = {hi_mask(r.ea, r.map[2:0]), 8'hFF};
        req_valid_i <= 1'b1;
        req_we_i <= r.we;
        req_addr_i <= r.addr;
        req_wdata_i <= r.wd;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < LIM);
        guard(n);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        ale_cnt = 0;
        rd_cnt = 0;
        wr_cnt = 0;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end while (rsp_valid_o !== 1'b1 && n < LIM);
        guard(n);
        check(16'(n), 16'(w + 1), "latency");
        check(16'(rsp_rdata_o), 16'(r.exp), "data");
        check(16'(sfr_sel_o), 16'(r.addr[15:8] == 8'hFF), "sfr");
        check(16'(ale_cnt), 16'(r.ext ? 2 : 0), "ale");
        check(16'(r.we ? wr_cnt : rd_cnt), 16'(r.ext ? w - 2 : 0), "strobe");
        check(16'(r.we ? rd_cnt : wr_cnt), 16'h0000, "other strobe");
        if (r.ext)
        begin
            check(lat & m, r.addr & m, "address");
            check(16'(st[8]), 16'(r.we), "bus dir");
            check(16'(r.we ? st[7:0] : r.wd), 16'(r.wd), "wdata");
        end
    endtask : run_row

    initial
    begin
        int n;
        logic s;
        rows[0] = '{1, 8'h04, 1, 16'h1234, 8'hA5, 8'hA5, 1};
        rows[1] = '{1, 8'h04, 0, 16'h1234, 8'h00, 8'hA5, 1};
        rows[2] = '{1, 8'h34, 0, 16'h1234, 8'h00, 8'hA5, 1};
        rows[3] = '{1, 8'h14, 1, 16'h00FF, 8'h3C, 8'h3C, 1};
        rows[4] = '{1, 8'h24, 0, 16'h00FF, 8'h00, 8'h3C, 1};
        rows[5] = '{1, 8'h02, 1, 16'h0ABC, 8'h71, 8'h71, 1};
        rows[6] = '{1, 8'h02, 0, 16'h0ABC, 8'h00, 8'h71, 1};
        rows[7] = '{1, 8'h03, 1, 16'h2D5E, 8'h96, 8'h96, 1};
        rows[8] = '{1, 8'h01, 0, 16'h00FF, 8'h00, 8'h3C, 1};
        rows[9] = '{0, 8'h00, 1, 16'h4321, 8'hE7, 8'hE7, 1};
        rows[10] = '{0, 8'h00, 0, 16'h4321, 8'h00, 8'hE7, 1};
        rows[11] = '{1, 8'h00, 0, 16'h1234, 8'h00, NO_MEM_DATA, 0};
        rows[12] = '{0, 8'h00, 0, 16'hFF10, 8'h00, 8'h5E, 0};
        repeat (15) @(posedge clk_i);
        @(negedge clk_i);
        check(16'(idle_pins), 16'h1C00, "reset pins");
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        check(16'(idle_pins), 16'h1C00, "idle pins");
        for (int i = 0; i < 4; i++)
        begin
            s = sys_clk_o;
            @(negedge clk_i);
            check(16'(sys_clk_o), 16'(!s), "sys clock");
        end
        foreach (rows[i])
            run_row(rows[i]);
        // The last row left external access low, which would claim all of port five.
        @(posedge clk_i);
        ext_access_n_i <= 1'b1;
        cfg(SEL_MEM_MAP, {5'h00, SIZE_4K});
        cfg(SEL_PORT_FIVE, 8'hC3);
        cfg(SEL_MODE_FIVE, 8'h5A);
        repeat (4) @(negedge clk_i);
        check(16'(p5_oe[7:4]), 16'h000A, "p5 spare dir");
        check(16'(port_five_o[7:4]), 16'h000C, "p5 spare out");
        check(16'(p5_in[7:4]), 16'h0008, "p5 spare in");
        cfg(SEL_MEM_MAP, {5'h00, SIZE_NONE});
        cfg(SEL_PORT_FOUR, 8'h96);
        cfg(SEL_MODE_FOUR, 8'hFE);
        repeat (4) @(negedge clk_i);
        check(16'(p5_oe), 16'h00A5, "p5 dir");
        check(16'({port_four_oe_o, port_four_o}), 16'h0196, "p4 out");
        cfg(SEL_MODE_FOUR, 8'h01);
        repeat (2) @(negedge clk_i);
        check(16'(port_four_oe_o), 16'h0000, "p4 in");
        @(negedge clk_i);
        check(16'(p4_in), 16'(port_four_i), "p4 pin in");
        for (int k = 3; k >= 0; k--)
        begin
            cfg(SEL_REFRESH, (8'h01 << RF_EN_BIT) | 8'(k));
            wait_fall(n);
            wait_fall(n);
            @(negedge clk_i);
            check(16'(refresh_pulse_n_o), 16'h0000, "pulse width");
            @(negedge clk_i);
            check(16'(refresh_pulse_n_o), 16'h0001, "pulse end");
            wait_fall(n);
            guard(n);
            check(16'(n + 2), 16'(REF << k), "interval");
        end
        for (int i = 0; i < 5; i++)
            run_row(rows[i]);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        @(negedge clk_i);
        check(16'(idle_pins), 16'h1C00, "mid reset");
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        wait_fall(n);
        check(16'(n), 16'(LIM), "refresh off");
        summarize();
    end
endmodule : testbench
